// *** design/pps_pkg.sv ***
package pps_pkg;
   // Register byte offsets
   localparam logic [3:0] ADDR_CFG = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_WAIT = 4'h8;
   // Configuration register fields
   localparam int CFG_AUTO = 0;
   localparam int CFG_HILIM = 1;
   localparam int CFG_PSEL = 2;
   localparam int CFG_SUSP = 3;
   // Configuration reset: auto on, high limit on, charger off
   localparam logic [3:0] CFG_RST = 4'h3;
   // Converter wait register fields
   localparam int WAIT_LVL_LO = 0;
   localparam int WAIT_SLEEP = 2;
   localparam logic [1:0] LVL_RST = 2'h0;
   // Status register fields
   localparam int ST_PATH_LO = 0;
   localparam int ST_SUPP = 2;
   localparam int ST_OVP = 3;
   localparam int ST_OSHORT = 4;
   localparam int ST_BSHORT = 5;
   localparam int ST_NOBAT = 6;
   localparam int ST_THERM = 7;
   // Clock and battery-absent deglitch time
   localparam int CLK_KHZ = 25000;
   localparam int DGL_US = 1000;
   localparam int DGL_CYC = (DGL_US * CLK_KHZ) / 1000;
   localparam int DGL_W = 20;
   // Comparator inputs, in sync vector order
   localparam int NCMP = 11;
   localparam int C_AC = 0;
   localparam int C_USB = 1;
   localparam int C_ACOV = 2;
   localparam int C_USBOV = 3;
   localparam int C_OSH = 4;
   localparam int C_BSH = 5;
   localparam int C_SUP = 6;
   localparam int C_DPM = 7;
   localparam int C_NOBAT = 8;
   localparam int C_TSD = 9;
   localparam int C_IZERO = 10;
   // Which source feeds the system bus
   typedef enum logic [1:0] {
      PATH_BAT,
      PATH_AC,
      PATH_USB
   } pps_path_t;
   // Bus-input current limit codes: 100 mA, 500 mA, 2.75 A
   typedef enum logic [1:0] {
      ILIM_100M,
      ILIM_500M,
      ILIM_2A75
   } pps_ilim_t;
endpackage

// *** design/pps_top.sv ***
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pps_top #(
   parameter int DGL_CYCLES = pps_pkg::DGL_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ac_present,
   input wire logic usb_present,
   input wire logic ac_overvolt,
   input wire logic usb_overvolt,
   input wire logic out_short_cmp,
   input wire logic bat_short_cmp,
   input wire logic supplement_cmp,
   input wire logic dpm_pin_low,
   input wire logic bat_absent_cmp,
   input wire logic thermal_shutdown,
   input wire logic charge_current_zero,
   output logic ac_switch_on,
   output logic usb_switch_on,
   output logic bat_switch_on,
   output logic input_pullup_en,
   output logic bat_pullup_en,
   output logic bat_discharge_en,
   output logic charge_reduce,
   output logic charger_enable,
   output pps_pkg::pps_ilim_t usb_ilim,
   output pps_pkg::pps_ilim_t ac_ilim,
   output logic pack_id_src_en,
   output logic [1:0] pack_id_current_level
);
   import pps_pkg::*;

   typedef struct packed {
      logic [NCMP-1:0] sync1;
      logic [NCMP-1:0] sync2;
      logic [3:0] cfg;
      logic [1:0] id_lvl;
      logic sleep;
      pps_path_t path;
      logic ovp_flag;
      logic nobat_flag;
      logic [DGL_W-1:0] dgl_cnt;
      logic wait_r;
      logic [31:0] rdata;
      logic ac_sw;
      logic usb_sw;
      logic bat_sw;
      logic in_pu;
      logic bat_pu;
      logic dis;
      logic reduce;
      logic chg_en;
      pps_ilim_t usb_lim;
      pps_ilim_t ac_lim;
      logic id_en;
   } pps_state_t;

   pps_state_t st_r;
   pps_state_t st_nxt;

   // Bus input limit decode; selector high overrides the high-limit bit
   function automatic pps_ilim_t ilim_dec(input logic psel, input logic hi);
      if (psel) begin
         ilim_dec = ILIM_2A75;
      end else if (hi) begin
         ilim_dec = ILIM_500M;
      end else begin
         ilim_dec = ILIM_100M;
      end
   endfunction

   // Status word assembly, shared by read-back
   function automatic logic [31:0] stat_word(input pps_state_t s,
                                            input logic [NCMP-1:0] c);
      logic [31:0] w;
      w = 32'h0;
      w[ST_PATH_LO +: 2] = s.path;
      w[ST_SUPP] = s.bat_sw && (s.path != PATH_BAT);
      w[ST_OVP] = s.ovp_flag;
      w[ST_OSHORT] = c[C_OSH];
      w[ST_BSHORT] = c[C_BSH] && !c[C_DPM];
      w[ST_NOBAT] = s.nobat_flag;
      w[ST_THERM] = c[C_TSD];
      stat_word = w;
   endfunction

   logic [NCMP-1:0] cmp_raw;
   assign cmp_raw = {charge_current_zero, thermal_shutdown, bat_absent_cmp,
                     dpm_pin_low, supplement_cmp, bat_short_cmp, out_short_cmp,
                     usb_overvolt, ac_overvolt, usb_present, ac_present};

   // Next-state logic; clock enable low holds everything
   always_comb begin
      logic [NCMP-1:0] c;
      logic req;
      logic acc;
      logic ovp_clr;
      logic bshort;
      pps_path_t np;
      st_nxt = st_r;
      c = st_r.sync2;
      req = avs_read || avs_write;
      acc = req && !st_r.wait_r;
      ovp_clr = 1'b0;
      bshort = 1'b0;
      np = PATH_BAT;
      if (clk_en) begin
         // Only the second stage is ever read by logic
         st_nxt.sync1 = cmp_raw;
         st_nxt.sync2 = st_r.sync1;
         // One wait cycle per access, then a single low cycle
         st_nxt.wait_r = !(req && st_r.wait_r);
         if (req && st_r.wait_r) begin
            case (avs_address)
               ADDR_CFG: st_nxt.rdata = {28'h0, st_r.cfg};
               ADDR_STAT: st_nxt.rdata = stat_word(st_r, c);
               ADDR_WAIT: st_nxt.rdata = {29'h0, st_r.sleep, st_r.id_lvl};
               default: st_nxt.rdata = 32'h0;
            endcase
         end
         if (acc && avs_write && avs_byteenable[0]) begin
            case (avs_address)
               ADDR_CFG: st_nxt.cfg = avs_writedata[3:0];
               ADDR_STAT: ovp_clr = avs_writedata[ST_OVP];
               ADDR_WAIT: begin
                  st_nxt.id_lvl = avs_writedata[WAIT_LVL_LO +: 2];
                  st_nxt.sleep = avs_writedata[WAIT_SLEEP];
               end
               default: ;
            endcase
         end
         // Sticky overvoltage flag; a new trip beats a clear
         if (c[C_ACOV] || c[C_USBOV]) begin
            st_nxt.ovp_flag = 1'b1;
         end else if (ovp_clr) begin
            st_nxt.ovp_flag = 1'b0;
         end
         // Deglitch: any gap in the absent level restarts the count
         if (!c[C_NOBAT]) begin
            st_nxt.dgl_cnt = '0;
            st_nxt.nobat_flag = 1'b0;
         end else if (st_r.dgl_cnt >= DGL_W'(DGL_CYCLES - 1)) begin
            st_nxt.nobat_flag = 1'b1;
         end else begin
            st_nxt.dgl_cnt = st_r.dgl_cnt + 1'b1;
         end
         st_nxt.dis = st_nxt.nobat_flag;
         // Priority pick, recomputed each cycle so a loss falls through
         if (c[C_AC]) begin
            np = PATH_AC;
         end else if (c[C_USB]) begin
            np = PATH_USB;
         end else begin
            np = PATH_BAT;
         end
         // Auto bit low ties the bus to the battery, even if it leaves
         if (!st_r.cfg[CFG_AUTO]) begin
            np = PATH_BAT;
         end
         st_nxt.path = np;
         // Blanked while the power loop pin is low
         bshort = c[C_BSH] && !c[C_DPM];
         // Overvoltage is deliberately not an input to the switches
         st_nxt.ac_sw = (np == PATH_AC);
         st_nxt.usb_sw = (np == PATH_USB);
         st_nxt.in_pu = 1'b0;
         // Supplement only once the charge current has been cut to zero
         st_nxt.reduce = (np != PATH_BAT) && c[C_SUP];
         if (np == PATH_BAT) begin
            st_nxt.bat_sw = 1'b1;
         end else begin
            st_nxt.bat_sw = c[C_SUP] && c[C_IZERO];
         end
         if (c[C_OSH]) begin
            st_nxt.ac_sw = 1'b0;
            st_nxt.usb_sw = 1'b0;
            st_nxt.in_pu = 1'b1;
         end
         if (c[C_TSD]) begin
            st_nxt.ac_sw = 1'b0;
            st_nxt.usb_sw = 1'b0;
            st_nxt.bat_sw = 1'b1;
            st_nxt.reduce = 1'b0;
         end
         // Battery short wins the battery switch: closing into a short is worse
         st_nxt.bat_pu = bshort;
         if (bshort) begin
            st_nxt.bat_sw = 1'b0;
         end
         st_nxt.chg_en = st_r.cfg[CFG_SUSP];
         st_nxt.usb_lim = ilim_dec(st_r.cfg[CFG_PSEL], st_r.cfg[CFG_HILIM]);
         st_nxt.ac_lim = ILIM_2A75;
         st_nxt.id_en = !st_r.sleep;
      end
   end

   // State register; reset values are the power-up configuration
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.cfg <= CFG_RST;
         st_r.id_lvl <= LVL_RST;
         st_r.wait_r <= 1'b1;
         st_r.path <= PATH_BAT;
         st_r.bat_sw <= 1'b1;
         st_r.usb_lim <= ILIM_500M;
         st_r.ac_lim <= ILIM_2A75;
         st_r.id_en <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign avs_readdata = st_r.rdata;
   assign avs_waitrequest = st_r.wait_r;
   assign ac_switch_on = st_r.ac_sw;
   assign usb_switch_on = st_r.usb_sw;
   assign bat_switch_on = st_r.bat_sw;
   assign input_pullup_en = st_r.in_pu;
   assign bat_pullup_en = st_r.bat_pu;
   assign bat_discharge_en = st_r.dis;
   assign charge_reduce = st_r.reduce;
   assign charger_enable = st_r.chg_en;
   assign usb_ilim = st_r.usb_lim;
   assign ac_ilim = st_r.ac_lim;
   assign pack_id_src_en = st_r.id_en;
   assign pack_id_current_level = st_r.id_lvl;
endmodule
`default_nettype wire

// *** tb/pps_analog.sv ***
`timescale 1ns/1ps
`default_nettype none
// Comparator bank of the far side; levels settle one edge after the bench asks
module pps_analog (
   input wire logic sys_clk,
   input wire logic [10:0] want,
   output logic [10:0] cmp = 11'h000
);
   // Registered on the sampling edge itself; the nonblocking update keeps the DUT from racing the new level
   always @(posedge sys_clk) begin
      cmp <= want;
   end
endmodule
`default_nettype wire

// *** tb/pps_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pps_props #(
   parameter int DGL_CYCLES = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ac_present,
   input wire logic usb_present,
   input wire logic out_short_cmp,
   input wire logic bat_short_cmp,
   input wire logic dpm_pin_low,
   input wire logic bat_absent_cmp,
   input wire logic thermal_shutdown,
   input wire logic ac_switch_on,
   input wire logic usb_switch_on,
   input wire logic bat_switch_on,
   input wire logic input_pullup_en,
   input wire logic bat_pullup_en,
   input wire logic bat_discharge_en,
   input wire pps_pkg::pps_ilim_t ac_ilim
);
   import pps_pkg::*;
   // Four steady samples cover the two sync stages plus the output register
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_therm_open: assert property (
      thermal_shutdown[*4] |-> !ac_switch_on && !usb_switch_on) else $error("inputs on in thermal");
   a_oshort_pull: assert property (
      out_short_cmp[*4] |-> !ac_switch_on && input_pullup_en) else $error("output short ignored");
   a_bshort_cut: assert property (
      (bat_short_cmp && !dpm_pin_low)[*4] |-> !bat_switch_on && bat_pullup_en)
      else $error("battery short ignored");
   a_dpm_blank: assert property (dpm_pin_low[*4] |-> !bat_pullup_en)
      else $error("short seen while blanked");
   a_one_input: assert property (!(ac_switch_on && usb_switch_on))
      else $error("both inputs closed");
   a_ac_fixed: assert property (ac_ilim == ILIM_2A75)
      else $error("adapter limit changed");
   a_no_ac: assert property (!ac_present[*4] |-> !ac_switch_on)
      else $error("adapter closed while absent");
   a_no_usb: assert property (!usb_present[*4] |-> !usb_switch_on)
      else $error("bus input closed while absent");
   a_dgl_held: assert property (
      $rose(bat_discharge_en) |-> $past(bat_absent_cmp, DGL_CYCLES))
      else $error("discharge before deglitch");
endmodule
bind pps_top pps_props #(.DGL_CYCLES(DGL_CYCLES)) i_pps_props(.sys_clk, .rst, .ac_present,
   .usb_present, .out_short_cmp, .bat_short_cmp, .dpm_pin_low, .bat_absent_cmp,
   .thermal_shutdown, .ac_switch_on, .usb_switch_on, .bat_switch_on, .input_pullup_en,
   .bat_pullup_en, .bat_discharge_en, .ac_ilim);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
   import pps_pkg::*;
   localparam int DG = 8;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [10:0] want = 11'h000;
   logic [10:0] cmp;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, ac_switch_on, usb_switch_on, bat_switch_on, input_pullup_en;
   logic bat_pullup_en, bat_discharge_en, charge_reduce, charger_enable, pack_id_src_en;
   pps_ilim_t usb_ilim, ac_ilim;
   logic [1:0] pack_id_current_level;
   int fails = 0;
   int checks = 0;
   pps_top #(.DGL_CYCLES(DG)) i_pps_top(.sys_clk, .rst, .clk_en(1'b1), .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
      .avs_waitrequest, .ac_present(cmp[C_AC]), .usb_present(cmp[C_USB]),
      .ac_overvolt(cmp[C_ACOV]), .usb_overvolt(cmp[C_USBOV]), .out_short_cmp(cmp[C_OSH]),
      .bat_short_cmp(cmp[C_BSH]), .supplement_cmp(cmp[C_SUP]), .dpm_pin_low(cmp[C_DPM]),
      .bat_absent_cmp(cmp[C_NOBAT]), .thermal_shutdown(cmp[C_TSD]),
      .charge_current_zero(cmp[C_IZERO]), .ac_switch_on, .usb_switch_on, .bat_switch_on,
      .input_pullup_en, .bat_pullup_en, .bat_discharge_en, .charge_reduce, .charger_enable,
      .usb_ilim, .ac_ilim, .pack_id_src_en, .pack_id_current_level);
   pps_analog i_pps_analog(.sys_clk, .want, .cmp);
   // 25 MHz system clock
   always #20 sys_clk = ~sys_clk;
   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // One bus access, held until waitrequest is sampled low; read data lands in q
   task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // No cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Six cycles: partner edge, two sync stages, output register, margin
   task automatic cm(input logic [10:0] v);
      want <= v;
      w(6);
   endtask
   task automatic t_reset();
      `CHK("bat", 1'b1, bat_switch_on)
      `CHK("ilim", ILIM_500M, usb_ilim)
      acc(0, ADDR_CFG, 32'h0);
      `CHK("cfg", {28'h0, CFG_RST}, q)
      $display("done reset");
   endtask
   // Drops from both inputs to bus input to none, then adapter alone
   task automatic t_prio();
      logic [10:0] vs[4] = '{11'h003, 11'h002, 11'h000, 11'h001};
      logic a, u;
      for (int i = 0; i < 4; i++) begin
         cm(vs[i]);
         a = vs[i][C_AC];
         u = vs[i][C_USB] & !a;
         `CHK("ac", a, ac_switch_on)
         `CHK("usb", u, usb_switch_on)
         `CHK("bat", !(a | u), bat_switch_on)
         acc(0, ADDR_STAT, 32'h0);
         `CHK("path", {u, a}, q[1:0])
      end
      $display("done prio");
   endtask
   task automatic t_cfg();
      acc(1, ADDR_CFG, 32'h2);
      cm(11'h003);
      `CHK("ac", 1'b0, ac_switch_on)
      `CHK("bat", 1'b1, bat_switch_on)
      for (int i = 0; i < 8; i++) begin
         acc(1, ADDR_CFG, {28'h0, i[2:0], 1'b1});
         w(3);
         `CHK("usb", i[1] ? ILIM_2A75 : i[0] ? ILIM_500M : ILIM_100M, usb_ilim)
         `CHK("ac", ILIM_2A75, ac_ilim)
         `CHK("chg", i[2], charger_enable)
      end
      acc(1, ADDR_CFG, 32'h3);
      $display("done cfg");
   endtask
   task automatic t_ovp();
      cm(11'h005);
      `CHK("ac", 1'b1, ac_switch_on)
      acc(0, ADDR_STAT, 32'h0);
      `CHK("ovp", 1'b1, q[ST_OVP])
      cm(11'h00A);
      `CHK("usb", 1'b1, usb_switch_on)
      cm(11'h002);
      acc(1, ADDR_STAT, 32'h8);
      acc(0, ADDR_STAT, 32'h0);
      `CHK("ovp", 1'b0, q[ST_OVP])
      $display("done ovp");
   endtask
   task automatic t_supp();
      cm(11'h441);
      `CHK("bat", 1'b1, bat_switch_on)
      acc(0, ADDR_STAT, 32'h0);
      `CHK("supp", 1'b1, q[ST_SUPP])
      cm(11'h041);
      `CHK("bat", 1'b0, bat_switch_on)
      `CHK("cut", 1'b1, charge_reduce)
      $display("done supp");
   endtask
   task automatic t_fault();
      cm(11'h201);
      `CHK("bat", 1'b1, bat_switch_on)
      cm(11'h011);
      `CHK("pull", 1'b1, input_pullup_en)
      cm(11'h021);
      `CHK("bpull", 1'b1, bat_pullup_en)
      cm(11'h0A1);
      `CHK("bpull", 1'b0, bat_pullup_en)
      cm(11'h001);
      `CHK("ac", 1'b1, ac_switch_on)
      $display("done fault");
   endtask
   task automatic t_pack();
      acc(1, ADDR_WAIT, 32'h6);
      w(3);
      `CHK("lvl", 2'h2, pack_id_current_level)
      `CHK("src", 1'b0, pack_id_src_en)
      acc(1, ADDR_WAIT, 32'h1);
      w(3);
      `CHK("src", 1'b1, pack_id_src_en)
      acc(0, 4'hC, 32'h0);
      `CHK("unmapped", 32'h0, q)
      $display("done pack");
   endtask
   // Early look catches a deglitch that is too short
   task automatic t_nobat();
      cm(11'h100);
      `CHK("dis", 1'b0, bat_discharge_en)
      w(DG);
      `CHK("dis", 1'b1, bat_discharge_en)
      cm(11'h000);
      `CHK("dis", 1'b0, bat_discharge_en)
      $display("done nobat");
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, well past the few hundred cycles the tests need
   initial begin
      w(3000);
      fails++;
      summarize();
   end
   initial begin
      w(5);
      rst <= 1'b0;
      t_reset();
      t_prio();
      t_cfg();
      t_ovp();
      t_supp();
      t_fault();
      t_pack();
      t_nobat();
      summarize();
   end
endmodule
`default_nettype wire
